// file: core/sst_transmitter.sv
// Purpose: synchronous bisync transmit channel behind an APB slave
// Assumes: x1 bit clock on txClk, data changes on its falling edge
// Notes: txClk and ctsN are asynchronous and pass three flip-flops
//
// How it works
// - Crc is 16-bit, polynomial x16+x15+x2+1 or x16+x12+x5+1 by host choice.
// - Outside bit-oriented framing, crc reset clears the register to zeros.
// - The reset-transmit-crc command initialises the transmit crc generator.
// - Transmitter and receiver checker share the one selected polynomial.
// - External/status interrupt on clear-to-send change and underrun latch set.
// - With auto enables, sending starts only while clear-to-send is active.
// - Output is marking after reset and once a disabled transmitter has finished the character in flight.
// - Send-break forces spacing at once, no character boundary awaited.
// - Enabled with no data, the sync character (8 or 16 bit) repeats.
// - Transmit interrupt enable raises interrupt on each buffer full-to-empty.
// - Pending empty interrupt clears on data write or reset-pending command.
// - After command clear with no data, no further empty interrupt; underrun.
// - Underrun/end-of-message status means sync sent or crc being sent.
// - Wait/ready output offers wait mode and ready mode for block transfers.
// - Status-affects-vector works on the second channel only.
// - Reset leaves the underrun/end-of-message bit set; fill syncs skip crc.
// - Ready mode asserts ready while the buffer is empty and channel runs.
// - Characters go out least-significant bit first, right justified.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
module sst_transmitter #(
    parameter bit CHAN_B = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic txClk,
    input wire logic ctsN,
    output logic txData,
    output logic rtsN,
    output logic dtrN,
    output logic intN,
    output logic waitReadyN,
    output logic polyCrc16
);
    logic [7:0] intCtl_reg, rxCtl_reg, mode_reg, syncLo_reg, syncHi_reg, txBuf_reg;
    sst_pkg::sst_txctl_t txCtl_reg;
    logic bufFull_reg, eom_reg, txPend_reg, extPend_reg, charCrc_reg;
    logic [15:0] shift_reg;
    logic [4:0] bitCnt_reg;
    sst_pkg::sst_kind_t kind_reg;
    logic [1:0] pinA_reg, pinB_reg, pinC_reg, pinLvl_reg, pinLvl_next;
    logic [15:0] crcVal, crcRev;
    sst_pkg::sst_char_t nextChar;
    logic [4:0] dataLen;
    logic [2:0] vecCode;
    logic [31:0] readData;
    logic access, wrDo, cmdWr, dataWr, regHit, stall;
    logic chanReset, crcClear, eomReset, pendReset, extReset;
    logic txFall, ctsChange, ctsActive, txRun, sdlc, sixteen;
    logic loadNow, bitStep, crcShift, crcBit, loadSync, eomRise;

    // link inputs: only the second and third stages are looked at
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinA_reg <= sst_pkg::PIN_RESET;
            pinB_reg <= sst_pkg::PIN_RESET;
            pinC_reg <= sst_pkg::PIN_RESET;
            pinLvl_reg <= sst_pkg::PIN_RESET;
        end else begin
            pinA_reg <= {txClk, ctsN};
            pinB_reg <= pinA_reg;
            pinC_reg <= pinB_reg;
            pinLvl_reg <= pinLvl_next;
        end
    end

    // a level counts only once stages two and three agree
    assign pinLvl_next = (pinB_reg & pinC_reg) | (pinLvl_reg & (pinB_reg | pinC_reg));
    assign txFall = pinLvl_reg[1] & ~pinLvl_next[1];
    assign ctsChange = pinLvl_reg[0] ^ pinLvl_next[0];
    assign ctsActive = ~pinLvl_reg[0];

    // apb decode; a request is taken when pready is seen high
    assign access = psel & penable & pready;
    assign wrDo = access & pwrite;
    assign cmdWr = wrDo && (paddr == sst_pkg::ADDR_CMD);
    assign dataWr = wrDo && (paddr == sst_pkg::ADDR_DATA);
    assign chanReset = cmdWr && (pwdata[sst_pkg::CMD_CODE_LSB +: 3] == sst_pkg::CMD_CHAN_RST);
    assign pendReset = cmdWr && (pwdata[sst_pkg::CMD_CODE_LSB +: 3] == sst_pkg::CMD_RST_TXPEND);
    assign extReset = cmdWr && (pwdata[sst_pkg::CMD_CODE_LSB +: 3] == sst_pkg::CMD_RST_EXT);
    assign crcClear = chanReset || (cmdWr && (pwdata[sst_pkg::CMD_CRC_LSB +: 2] == sst_pkg::CRC_RST_TX));
    assign eomReset = cmdWr && (pwdata[sst_pkg::CMD_CRC_LSB +: 2] == sst_pkg::CRC_RST_EOM);
    // wait mode holds off a data write while the buffer is still full
    assign stall = intCtl_reg[sst_pkg::INT_WR_EN] && !intCtl_reg[sst_pkg::INT_WR_READY]
        && pwrite && (paddr == sst_pkg::ADDR_DATA) && bufFull_reg;

    assign txRun = txCtl_reg.txEnable && (!rxCtl_reg[sst_pkg::RX_AUTO_EN] || ctsActive);
    assign sdlc = mode_reg[sst_pkg::MODE_SYNC_LSB +: 2] == sst_pkg::SYNC_SDLC;
    assign sixteen = mode_reg[sst_pkg::MODE_SYNC_LSB +: 2] == sst_pkg::SYNC_16;

    // crc goes out high bit first, so it is reversed for the lsb-first shifter
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_rev
            assign crcRev[gi] = crcVal[15 - gi];
        end
    endgenerate

    always_comb begin
        case (txCtl_reg.charLen)
            sst_pkg::LEN_5: dataLen = sst_pkg::BITS_5;
            sst_pkg::LEN_6: dataLen = sst_pkg::BITS_6;
            sst_pkg::LEN_7: dataLen = sst_pkg::BITS_7;
            default: dataLen = sst_pkg::BITS_8;
        endcase
    end

    // choice of the next character at a boundary
    always_comb begin
        if (bufFull_reg) begin
            nextChar.word = {8'h00, txBuf_reg};
            nextChar.len = dataLen;
            nextChar.inCrc = txCtl_reg.txCrcEn;
            nextChar.kind = sst_pkg::KIND_DATA;
        end else if (!eom_reg) begin
            nextChar.word = crcRev;
            nextChar.len = sst_pkg::BITS_16;
            nextChar.inCrc = 1'b0;
            nextChar.kind = sst_pkg::KIND_CRC;
        end else begin
            nextChar.word = sixteen ? {syncHi_reg, syncLo_reg} : {8'h00, syncLo_reg};
            nextChar.len = sixteen ? sst_pkg::BITS_16 : sst_pkg::BITS_8;
            nextChar.inCrc = 1'b0;
            nextChar.kind = sst_pkg::KIND_SYNC;
        end
    end

    assign loadNow = txFall && (bitCnt_reg == 5'd0) && txRun && !txCtl_reg.sendBreak;
    assign bitStep = txFall && (bitCnt_reg != 5'd0) && !txCtl_reg.sendBreak;
    assign crcShift = (loadNow && nextChar.inCrc) || (bitStep && charCrc_reg);
    assign crcBit = loadNow ? nextChar.word[0] : shift_reg[0];
    assign loadSync = loadNow && !bufFull_reg && eom_reg;
    assign eomRise = loadNow && !bufFull_reg && !eom_reg;

    sst_crc16 u_crc (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(crcClear),
        .clearOnes(sdlc),
        .polyCrc16(txCtl_reg.crc16Sel),
        .shiftEn(crcShift),
        .dataBit(crcBit),
        .crc(crcVal)
    );

    // shift engine, stepping on each falling edge of the bit clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_reg <= 16'h0000;
            bitCnt_reg <= 5'd0;
            kind_reg <= sst_pkg::KIND_IDLE;
            charCrc_reg <= 1'b0;
            txData <= 1'b1;
        end else if (chanReset || txCtl_reg.sendBreak) begin
            // break drops whatever is in flight
            shift_reg <= 16'h0000;
            bitCnt_reg <= 5'd0;
            kind_reg <= sst_pkg::KIND_IDLE;
            charCrc_reg <= 1'b0;
            txData <= chanReset || !txCtl_reg.sendBreak;
        end else if (loadNow) begin
            txData <= nextChar.word[0];
            shift_reg <= {1'b0, nextChar.word[15:1]};
            bitCnt_reg <= nextChar.len - 5'd1;
            kind_reg <= nextChar.kind;
            charCrc_reg <= nextChar.inCrc;
        end else if (bitStep) begin
            txData <= shift_reg[0];
            shift_reg <= {1'b0, shift_reg[15:1]};
            bitCnt_reg <= bitCnt_reg - 5'd1;
        end else if (txFall && bitCnt_reg == 5'd0) begin
            // disabled: the character in flight finished, now mark
            txData <= 1'b1;
            kind_reg <= sst_pkg::KIND_IDLE;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            intCtl_reg <= sst_pkg::REG_RESET;
            rxCtl_reg <= sst_pkg::REG_RESET;
            mode_reg <= sst_pkg::REG_RESET;
            txCtl_reg <= sst_pkg::TXCTL_RESET;
            syncLo_reg <= sst_pkg::REG_RESET;
            syncHi_reg <= sst_pkg::REG_RESET;
        end else if (chanReset) begin
            intCtl_reg <= sst_pkg::REG_RESET;
            rxCtl_reg <= sst_pkg::REG_RESET;
            mode_reg <= sst_pkg::REG_RESET;
            txCtl_reg <= sst_pkg::TXCTL_RESET;
            syncLo_reg <= sst_pkg::REG_RESET;
            syncHi_reg <= sst_pkg::REG_RESET;
        end else if (wrDo) begin
            case (paddr)
                sst_pkg::ADDR_INTCTL: intCtl_reg <= pwdata[7:0];
                sst_pkg::ADDR_RXCTL: rxCtl_reg <= pwdata[7:0];
                sst_pkg::ADDR_MODE: mode_reg <= pwdata[7:0];
                sst_pkg::ADDR_TXCTL: txCtl_reg <= pwdata[7:0];
                sst_pkg::ADDR_SYNCL: syncLo_reg <= pwdata[7:0];
                sst_pkg::ADDR_SYNCH: syncHi_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // transmit buffer; a break loses the buffered character
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txBuf_reg <= sst_pkg::REG_RESET;
            bufFull_reg <= 1'b0;
        end else if (chanReset || txCtl_reg.sendBreak) begin
            bufFull_reg <= 1'b0;
        end else if (dataWr) begin
            txBuf_reg <= pwdata[7:0];
            bufFull_reg <= 1'b1;
        end else if (loadNow && bufFull_reg) begin
            bufFull_reg <= 1'b0;
        end
    end

    // underrun/end-of-message latch: set at crc start beats the reset command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eom_reg <= sst_pkg::EOM_RESET;
        end else if (chanReset || eomRise) begin
            eom_reg <= 1'b1;
        end else if (eomReset) begin
            eom_reg <= 1'b0;
        end
    end

    // buffer-empty interrupt: only a full-to-empty move or the end of crc sets it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txPend_reg <= 1'b0;
        end else if (chanReset) begin
            txPend_reg <= 1'b0;
        end else if (intCtl_reg[sst_pkg::INT_TX_EN]
            && ((loadNow && bufFull_reg) || (loadSync && kind_reg == sst_pkg::KIND_CRC))) begin
            txPend_reg <= 1'b1;
        end else if (dataWr || pendReset) begin
            txPend_reg <= 1'b0;
        end
    end

    // external/status interrupt
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            extPend_reg <= 1'b0;
        end else if (chanReset) begin
            extPend_reg <= 1'b0;
        end else if (intCtl_reg[sst_pkg::INT_EXT_EN]
            && (ctsChange || eomRise || (loadSync && kind_reg == sst_pkg::KIND_DATA))) begin
            extPend_reg <= 1'b1;
        end else if (extReset) begin
            extPend_reg <= 1'b0;
        end
    end

    always_comb begin
        if (CHAN_B && intCtl_reg[sst_pkg::INT_SAV]) begin
            vecCode = extPend_reg ? sst_pkg::VEC_EXT
                : (txPend_reg ? sst_pkg::VEC_TX_EMPTY : sst_pkg::VEC_NONE);
        end else begin
            vecCode = sst_pkg::VEC_NONE;
        end
    end

    // pins toward modem, interrupt and transfer logic
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rtsN <= 1'b1;
            dtrN <= 1'b1;
            intN <= 1'b1;
            waitReadyN <= 1'b1;
            polyCrc16 <= 1'b0;
        end else begin
            rtsN <= ~txCtl_reg.rts;
            dtrN <= ~txCtl_reg.dtr;
            intN <= ~(txPend_reg | extPend_reg);
            polyCrc16 <= txCtl_reg.crc16Sel;
            waitReadyN <= ~(intCtl_reg[sst_pkg::INT_WR_EN]
                && (intCtl_reg[sst_pkg::INT_WR_READY] ? (!bufFull_reg && txRun) : bufFull_reg));
        end
    end

    always_comb begin
        readData = 32'h0000_0000;
        regHit = 1'b1;
        case (paddr)
            sst_pkg::ADDR_CMD: readData = 32'h0000_0000;
            sst_pkg::ADDR_INTCTL: readData[7:0] = intCtl_reg;
            sst_pkg::ADDR_RXCTL: readData[7:0] = rxCtl_reg;
            sst_pkg::ADDR_MODE: readData[7:0] = mode_reg;
            sst_pkg::ADDR_TXCTL: readData[7:0] = txCtl_reg;
            sst_pkg::ADDR_SYNCL: readData[7:0] = syncLo_reg;
            sst_pkg::ADDR_SYNCH: readData[7:0] = syncHi_reg;
            sst_pkg::ADDR_DATA: readData[7:0] = txBuf_reg;
            sst_pkg::ADDR_STATUS: begin
                readData[sst_pkg::ST_INT_PEND] = txPend_reg | extPend_reg;
                readData[sst_pkg::ST_TX_EMPTY] = !bufFull_reg;
                readData[sst_pkg::ST_CTS] = ctsActive;
                readData[sst_pkg::ST_EOM] = eom_reg;
                readData[sst_pkg::ST_VEC_LSB +: 3] = vecCode;
            end
            default: regHit = 1'b0;
        endcase
    end

    // one wait state in every access, more while wait mode stalls
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready && !stall;
            pslverr <= psel && penable && !pready && !stall && !regHit;
            if (psel && penable && !pready && !stall) begin
                prdata <= pwrite ? 32'h0000_0000 : readData;
            end
        end
    end
endmodule : sst_transmitter

// file: core/sst_pkg.sv
// Purpose: shared constants and types of the synchronous serial transmitter
// Assumes: 32-bit APB register bus, one aligned word per register
// Notes: offsets are byte addresses
package sst_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_INTCTL = 8'h04;
    localparam logic [7:0] ADDR_RXCTL = 8'h0c;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_TXCTL = 8'h14;
    localparam logic [7:0] ADDR_SYNCL = 8'h18;
    localparam logic [7:0] ADDR_SYNCH = 8'h1c;
    localparam logic [7:0] ADDR_DATA = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // command_pointer_register fields and codes
    localparam int CMD_CODE_LSB = 3;
    localparam int CMD_CRC_LSB = 6;
    localparam logic [2:0] CMD_RST_EXT = 3'h2;
    localparam logic [2:0] CMD_CHAN_RST = 3'h3;
    localparam logic [2:0] CMD_RST_TXPEND = 3'h5;
    localparam logic [1:0] CRC_RST_TX = 2'h2;
    localparam logic [1:0] CRC_RST_EOM = 2'h3;

    // interrupt_control_register bits
    localparam int INT_EXT_EN = 0;
    localparam int INT_TX_EN = 1;
    localparam int INT_SAV = 2;
    localparam int INT_WR_READY = 6;
    localparam int INT_WR_EN = 7;

    // receive_control_register and channel_mode_register fields
    localparam int RX_AUTO_EN = 5;
    localparam int MODE_SYNC_LSB = 4;
    localparam logic [1:0] SYNC_16 = 2'h1;
    localparam logic [1:0] SYNC_SDLC = 2'h2;

    // transmit_control_register layout, bit 7 down to bit 0
    typedef struct packed {
        logic dtr;
        logic [1:0] charLen;
        logic sendBreak;
        logic txEnable;
        logic crc16Sel;
        logic rts;
        logic txCrcEn;
    } sst_txctl_t;
    localparam logic [1:0] LEN_5 = 2'h0;
    localparam logic [1:0] LEN_6 = 2'h2;
    localparam logic [1:0] LEN_7 = 2'h1;
    localparam logic [4:0] BITS_5 = 5'd5;
    localparam logic [4:0] BITS_6 = 5'd6;
    localparam logic [4:0] BITS_7 = 5'd7;
    localparam logic [4:0] BITS_8 = 5'd8;
    localparam logic [4:0] BITS_16 = 5'd16;

    // primary_status_register bits
    localparam int ST_INT_PEND = 1;
    localparam int ST_TX_EMPTY = 2;
    localparam int ST_CTS = 5;
    localparam int ST_EOM = 6;
    localparam int ST_VEC_LSB = 8;
    localparam logic [2:0] VEC_TX_EMPTY = 3'h0;
    localparam logic [2:0] VEC_EXT = 3'h1;
    localparam logic [2:0] VEC_NONE = 3'h3;

    // crc polynomials and clear values
    localparam logic [15:0] POLY_CRC16 = 16'h8005;
    localparam logic [15:0] POLY_CCITT = 16'h1021;
    localparam logic [15:0] CRC_ZERO = 16'h0000;
    localparam logic [15:0] CRC_ONES = 16'hffff;

    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam sst_txctl_t TXCTL_RESET = '0;
    localparam logic EOM_RESET = 1'b1;
    localparam logic [1:0] PIN_RESET = 2'h3;

    typedef enum logic [1:0] {KIND_IDLE, KIND_DATA, KIND_SYNC, KIND_CRC} sst_kind_t;

    // one character ready to enter the shift register
    typedef struct packed {
        logic [15:0] word;
        logic [4:0] len;
        logic inCrc;
        sst_kind_t kind;
    } sst_char_t;
endpackage : sst_pkg

// file: core/sst_crc16.sv
// Purpose: 16-bit crc accumulator, one bit per shift
// Assumes: bits arrive in line order
// Notes: clear beats shift in the same cycle
`timescale 1ns/1ps
module sst_crc16 (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic clearOnes,
    input wire logic polyCrc16,
    input wire logic shiftEn,
    input wire logic dataBit,
    output logic [15:0] crc
);
    logic feedback;
    logic [15:0] poly;

    assign feedback = dataBit ^ crc[15];
    assign poly = polyCrc16 ? sst_pkg::POLY_CRC16 : sst_pkg::POLY_CCITT;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            crc <= sst_pkg::CRC_ZERO;
        end else if (clear) begin
            crc <= clearOnes ? sst_pkg::CRC_ONES : sst_pkg::CRC_ZERO;
        end else if (shiftEn) begin
            crc <= {crc[14:0], 1'b0} ^ (feedback ? poly : sst_pkg::CRC_ZERO);
        end
    end
endmodule : sst_crc16

// file: test/sst_line_rx.sv
// Purpose: remote bisync receiver that clocks the line and collects bits
// Assumes: x1 clock, sender launches each bit after a falling clock edge
// Notes: clock runs free because sync fill keeps the line busy between messages
`timescale 1ns/1ps
module sst_line_rx (
    output logic txClk,
    input wire logic txData,
    output logic [15:0] rxShift
);
    initial begin
        txClk = 1'b1;
        #37;
        forever #100 txClk = ~txClk;
    end

    // sample at the next fall: the synchroniser delays launch until 24.5 ns before the rise
    always @(negedge txClk) begin
        rxShift <= {txData, rxShift[15:1]};
    end
endmodule : sst_line_rx

// file: test/sst_assertions.sv
// Purpose: port-level assertions for the sync transmitter
// Assumes: sees only the top module ports
// Notes: helper regs mirror host writes; channel reset command clears all but everOn_reg
`timescale 1ns/1ps
module sst_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ctsN,
    input wire logic txData,
    input wire logic intN,
    input wire logic polyCrc16
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic wrAck, chanRst, polySel_reg, extEn_reg, everOn_reg;
    assign wrAck = psel && penable && pready && pwrite;
    assign chanRst = wrAck && paddr == sst_pkg::ADDR_CMD && pwdata[5:3] == sst_pkg::CMD_CHAN_RST;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst || chanRst) polySel_reg <= 1'b0;
        else if (wrAck && paddr == sst_pkg::ADDR_TXCTL) polySel_reg <= pwdata[2];
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst || chanRst) extEn_reg <= 1'b0;
        else if (wrAck && paddr == sst_pkg::ADDR_INTCTL) extEn_reg <= pwdata[0];
    end
    // channel reset leaves it: only rst proves the line idle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) everOn_reg <= 1'b0;
        else if (wrAck && paddr == sst_pkg::ADDR_TXCTL && (pwdata[3] || pwdata[4])) everOn_reg <= 1'b1;
    end
    apb_answer_a: assert property (psel && $rose(penable) && paddr != sst_pkg::ADDR_DATA |=> pready)
        else $error("register access not answered in time");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h0c, 8'h10,
        8'h14, 8'h18, 8'h1c, 8'h20, 8'h24})) else $error("error response wrong for address");
    cmd_read_a: assert property (pready && !pwrite && paddr == sst_pkg::ADDR_CMD |-> prdata == 32'h0)
        else $error("command register read not zero");
    mark_reset_a: assert property ($past(rst) |-> txData)
        else $error("line not marking after reset");
    mark_idle_a: assert property (!everOn_reg |-> txData)
        else $error("line left marking before enable");
    break_space_a: assert property (wrAck && paddr == sst_pkg::ADDR_TXCTL && pwdata[4] |-> ##[1:2] !txData)
        else $error("break did not space the line");
    poly_track_a: assert property (!wrAck [*3] |-> polyCrc16 == polySel_reg)
        else $error("checker polynomial differs from selection");
    cts_int_a: assert property (extEn_reg && $changed(ctsN) |-> ##[1:10] !intN)
        else $error("no interrupt on clear-to-send change");
endmodule : sst_checker

bind sst_transmitter sst_checker u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctsN(ctsN), .txData(txData), .intN(intN), .polyCrc16(polyCrc16));

// file: test/tb_sync_serial_transmitter.sv
// Purpose: self-checking bench for the sync transmitter over APB
// Assumes: remote receiver model clocks the line at 200 ns per bit
// Notes: line waits count bit times
`timescale 1ns/1ps
module tb_sync_serial_transmitter;
    logic clk_sys, rst, psel, penable, pwrite, ctsN, pready, pslverr, lastErr, found;
    logic txClk, txData, rtsN, dtrN, intN, waitReadyN, polyCrc16;
    logic [7:0] paddr;
    logic [15:0] rxShift;
    logic [31:0] pwdata, prdata, q;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    sst_transmitter u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txClk(txClk),
        .ctsN(ctsN), .txData(txData), .rtsN(rtsN), .dtrN(dtrN), .intN(intN), .waitReadyN(waitReadyN),
        .polyCrc16(polyCrc16));
    sst_line_rx u_line (.txClk(txClk), .txData(txData), .rxShift(rxShift));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            $display("MISMATCH at %0t: timeout got %h exp %h", $time, cycles, 0);
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic bits(input int n);
        repeat (n) @(negedge txClk);
        @(posedge clk_sys);
    endtask : bits
    function automatic logic [31:0] cmd(input logic [2:0] code, input logic [1:0] crc);
        return {24'h0, crc, code, 3'h0};
    endfunction : cmd
    function automatic logic [31:0] txc(input logic en, input logic brk, input logic crcEn);
        sst_pkg::sst_txctl_t t;
        t = sst_pkg::TXCTL_RESET;
        t.charLen = 2'h3;
        t.crc16Sel = 1'b1;
        t.txEnable = en;
        t.rts = en;
        t.sendBreak = brk;
        t.txCrcEn = crcEn;
        return {24'h0, t};
    endfunction : txc
    function automatic logic rotOk(input logic [15:0] s);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (s[15:8] === s[7:0] && 8'({s[7:0], s[7:0]} >> i) === 8'h16) r = 1'b1;
        end
        return r;
    endfunction : rotOk
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ctsN = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(txData, 1'b1);
        rd(sst_pkg::ADDR_STATUS);
        chk(q[6], 1'b1);
        chk(q[2], 1'b1);
        rd(sst_pkg::ADDR_CMD);
        rd(8'h08);
        chk(lastErr, 1'b1);
        $display("test reset done");
        wr(sst_pkg::ADDR_MODE, 32'h00);
        wr(sst_pkg::ADDR_SYNCL, 32'h16);
        wr(sst_pkg::ADDR_CMD, cmd(3'h0, sst_pkg::CRC_RST_TX));
        wr(sst_pkg::ADDR_TXCTL, txc(1'b1, 1'b0, 1'b0));
        bits(40);
        chk(polyCrc16, 1'b1);
        chk(rtsN, 1'b0);
        chk(rotOk(rxShift), 1'b1);
        $display("test sync fill done");
        wr(sst_pkg::ADDR_DATA, 32'ha5);
        found = 1'b0;
        repeat (40) begin
            @(negedge txClk);
            if (rxShift[15:8] === 8'ha5)
                found = 1'b1;
        end
        @(posedge clk_sys);
        chk(found, 1'b1);
        $display("test data order done");
        wr(sst_pkg::ADDR_INTCTL, 32'h02);
        wr(sst_pkg::ADDR_DATA, 32'h3c);
        bits(30);
        chk(intN, 1'b0);
        wr(sst_pkg::ADDR_CMD, cmd(sst_pkg::CMD_RST_TXPEND, 2'h0));
        repeat (3) @(posedge clk_sys);
        chk(intN, 1'b1);
        bits(30);
        chk(intN, 1'b1);
        rd(sst_pkg::ADDR_STATUS);
        chk(q[2], 1'b1);
        $display("test empty interrupt done");
        wr(sst_pkg::ADDR_INTCTL, 32'h01);
        wr(sst_pkg::ADDR_CMD, cmd(sst_pkg::CMD_RST_EXT, 2'h0));
        wr(sst_pkg::ADDR_TXCTL, txc(1'b1, 1'b0, 1'b1));
        wr(sst_pkg::ADDR_DATA, 32'h81);
        wr(sst_pkg::ADDR_CMD, cmd(3'h0, sst_pkg::CRC_RST_EOM));
        rd(sst_pkg::ADDR_STATUS);
        chk(q[6], 1'b0);
        found = 1'b0;
        repeat (40) begin
            @(negedge txClk);
            if (rxShift === 16'h60c0)
                found = 1'b1;
        end
        @(posedge clk_sys);
        chk(found, 1'b1);
        rd(sst_pkg::ADDR_STATUS);
        chk(q[6], 1'b1);
        chk(intN, 1'b0);
        wr(sst_pkg::ADDR_CMD, cmd(sst_pkg::CMD_RST_EXT, 2'h0));
        $display("test end of message done");
        wr(sst_pkg::ADDR_TXCTL, txc(1'b1, 1'b1, 1'b0));
        repeat (2) @(posedge clk_sys);
        chk(txData, 1'b0);
        wr(sst_pkg::ADDR_TXCTL, txc(1'b0, 1'b0, 1'b0));
        bits(40);
        chk(txData, 1'b1);
        $display("test break done");
        wr(sst_pkg::ADDR_RXCTL, 32'h20);
        wr(sst_pkg::ADDR_INTCTL, 32'hc1);
        wr(sst_pkg::ADDR_TXCTL, txc(1'b1, 1'b0, 1'b0));
        bits(20);
        chk(txData, 1'b1);
        chk(waitReadyN, 1'b1);
        ctsN <= 1'b0;
        bits(40);
        chk(rotOk(rxShift), 1'b1);
        chk(waitReadyN, 1'b0);
        wr(sst_pkg::ADDR_INTCTL, 32'hc5);
        rd(sst_pkg::ADDR_STATUS);
        chk(q[10:8], sst_pkg::VEC_EXT);
        wr(sst_pkg::ADDR_INTCTL, 32'h80);
        repeat (2) wr(sst_pkg::ADDR_DATA, 32'h55);
        @(posedge clk_sys);
        chk(waitReadyN, 1'b0);
        $display("test auto enable done");
        tally_and_finish();
    end
endmodule : tb_sync_serial_transmitter
